// file: logic/cesc_pkg.sv
package cesc_pkg;
  // Word addresses in the engine data RAM
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CONFIG    = 8'h20;
  localparam logic [7:0] ADDR_UV_LEVEL  = 8'h24;
  localparam logic [7:0] ADDR_GAIN      = 8'h40;
  localparam logic [7:0] ADDR_RATE_REAL = 8'h45;
  localparam logic [7:0] ADDR_RATE_REAC = 8'h46;
  localparam logic [7:0] ADDR_RATE_TWO  = 8'h47;
  localparam logic [7:0] ADDR_RATE_THR  = 8'h48;
  localparam logic [7:0] ADDR_COEF_LIN  = 8'h49;
  localparam logic [7:0] ADDR_COEF_QUAD = 8'h4a;
  localparam logic [7:0] ADDR_STATUS    = 8'h80;
  // Reset values and configuration write mask
  localparam logic [31:0] CONFIG_RST   = 32'h0000_5020;
  localparam logic [31:0] CONFIG_WMASK = 32'h000f_ffef;
  localparam logic [31:0] UV_LEVEL_RST = 32'h0006_c278;
  localparam logic [31:0] GAIN_RST     = 32'h0000_4000;
  // Configuration fields
  localparam int unsigned CFG_MASK_B   = 19;
  localparam int unsigned CFG_MASK_A   = 18;
  localparam int unsigned CFG_SAG_INT  = 17;
  localparam int unsigned CFG_TEMP_EXT = 16;
  localparam int unsigned CFG_CNT_HI   = 15;
  localparam int unsigned CFG_CNT_LO   = 8;
  localparam int unsigned CFG_SEL_HI   = 7;
  localparam int unsigned CFG_SEL_LO   = 6;
  localparam int unsigned CFG_PSRC     = 5;
  localparam int unsigned CFG_SHUNT_B  = 3;
  localparam int unsigned CFG_SHUNT_A  = 2;
  // Status fields
  localparam int unsigned ST_FUND  = 28;
  localparam int unsigned ST_SAG_B = 26;
  localparam int unsigned ST_SAG_A = 25;
  // Datapath constants
  localparam int unsigned SHUNT_SHIFT = 3;
  localparam int unsigned LIN_SHIFT   = 14;
  localparam int unsigned QUAD_SHIFT  = 23;
  localparam logic [2:0]  EQU_ONE_EL  = 3'h0;
  localparam logic [2:0]  EQU_TWO_EL  = 3'h2;
endpackage

// file: logic/cesc_ram.sv
`timescale 1ns/1ns
module cesc_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 32
) (
  // Clock
  input  wire logic          clk,
  input  wire logic          ce,
  // Port
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);
  if (AW < 1 || AW > 12 || DW < 1) begin : g_bad_size
    $error("cesc_ram: bad size");
  end

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (ce && wr) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata_q <= mem[addr];
    end
  end
endmodule

// file: logic/cesc_top.sv
// Behaviour
// - Status word snapshots flags of the last pass, rewritten on every pass end.
// - Phase B sag flag bit 26 sets after count low samples, holds till above.
// - Phase A sag flag bit 25 sets after count low samples, holds till above.
// - Status bits 31:29 and 24:0 always read zero.
// - Status bit 28 is a square wave at the selected phase's fundamental.
// - Configuration word packs the mode bits and sag count, reset value 0x5020.
// - Masks 19/18 pick phases; interrupt only while all enabled phases sag.
// - Bit 17 routes the sag interrupt to the auxiliary pulse pin.
// - Bit 16 clear: engine updates gain scale from temperature; set: host owns it.
// - Bits 7:6 select PLL phase: 00 phase A, 01 phase B.
// - Shunt gain bit set multiplies that current input by eight.
// - Pulse source 1: generators take four host-written rate words.
// - Source 0, equation 2: real and reactive pulse inputs are element sums, no creep control.
// - Source 0, equation 0: real pulse follows element with larger current square.
// - Pulse source select sits in configuration bit 5.
// - Undervoltage level is a word at engine address 0x24.
`timescale 1ns/1ns
module cesc_top
  import cesc_pkg::*;
#(
  parameter int unsigned MEM_AW = cesc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // Host word port into engine data RAM
  input  wire logic                         host_wr,
  input  wire logic                         host_rd,
  input  wire logic [cesc_pkg::ADDR_W-1:0]  host_addr,
  input  wire logic [31:0]                  host_wdata,
  output logic      [31:0]                  host_rdata_q,
  output logic                              host_rvalid_q,
  // Engine pass and samples
  input  wire logic                         pass_done,
  input  wire logic                         sample_valid,
  input  wire logic signed [31:0]           volt_a,
  input  wire logic signed [31:0]           volt_b,
  input  wire logic signed [31:0]           temp_delta,
  // Current channels
  input  wire logic signed [31:0]           chan_a_in,
  input  wire logic signed [31:0]           chan_b_in,
  output logic signed [31:0]                chan_a_out_q,
  output logic signed [31:0]                chan_b_out_q,
  // Energy sums
  input  wire logic [2:0]                   meter_equation,
  input  wire logic signed [31:0]           elem0_real_energy,
  input  wire logic signed [31:0]           elem1_real_energy,
  input  wire logic signed [31:0]           elem0_reactive_energy,
  input  wire logic signed [31:0]           elem1_reactive_energy,
  input  wire logic [31:0]                  elem0_current_square,
  input  wire logic [31:0]                  elem1_current_square,
  // Pulse generator inputs
  output logic [31:0]                       pulse_real_q,
  output logic [31:0]                       pulse_reactive_q,
  output logic [31:0]                       pulse_two_q,
  output logic [31:0]                       pulse_three_q,
  output logic [1:0]                        pulse_gain_q,
  // PLL and pins
  output logic                              pll_phase_b_q,
  output logic                              aux_pulse_pin_q,
  output logic [31:0]                       gain_scale_q
);
  import cesc_pkg::*;

  if (MEM_AW != ADDR_W) begin : g_bad_aw
    $error("cesc_top: MEM_AW must equal ADDR_W");
  end

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? 32'(-v) : 32'(v);
  endfunction

  logic [31:0] config_q;
  logic [31:0] uv_level_q;
  logic [31:0] status_q;
  logic [31:0] rate_q [4];
  logic signed [31:0] coef_lin_q;
  logic signed [31:0] coef_quad_q;
  logic [7:0]  cnt_q [2];
  logic [1:0]  sag_q;
  logic        fund_q;
  logic [31:0] reg_rd_q;
  logic        sel_mem_q;
  logic        rd_pend_q;
  logic [31:0] mem_rdata;
  logic        mapped;
  logic        sag_irq;
  logic signed [63:0] lin_term;
  logic signed [63:0] quad_term;

  always_comb begin
    unique case (host_addr)
      ADDR_CONFIG, ADDR_UV_LEVEL, ADDR_GAIN, ADDR_RATE_REAL, ADDR_RATE_REAC,
      ADDR_RATE_TWO, ADDR_RATE_THR, ADDR_COEF_LIN, ADDR_COEF_QUAD,
      ADDR_STATUS: mapped = 1'b1;
      default:     mapped = 1'b0;
    endcase
  end

  cesc_ram #(.AW(MEM_AW), .DW(32)) u_ram (
    .clk     (clk),
    .ce      (ce),
    .wr      (host_wr && !mapped),
    .addr    (host_addr),
    .wdata   (host_wdata),
    .rdata_q (mem_rdata)
  );

  // Host writes to configuration and parameter words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_q    <= CONFIG_RST;
      uv_level_q  <= UV_LEVEL_RST;
      coef_lin_q  <= '0;
      coef_quad_q <= '0;
      for (int i = 0; i < 4; i++) rate_q[i] <= '0;
    end else if (ce && host_wr) begin
      unique case (host_addr)
        ADDR_CONFIG:    config_q    <= host_wdata & CONFIG_WMASK;
        ADDR_UV_LEVEL:  uv_level_q  <= host_wdata;
        ADDR_RATE_REAL: rate_q[0]   <= host_wdata;
        ADDR_RATE_REAC: rate_q[1]   <= host_wdata;
        ADDR_RATE_TWO:  rate_q[2]   <= host_wdata;
        ADDR_RATE_THR:  rate_q[3]   <= host_wdata;
        ADDR_COEF_LIN:  coef_lin_q  <= host_wdata;
        ADDR_COEF_QUAD: coef_quad_q <= host_wdata;
        default: ;
      endcase
    end
  end

  // Gain scale ownership
  assign lin_term  = (64'(coef_lin_q) * 64'(temp_delta)) >>> LIN_SHIFT;
  assign quad_term = (64'(coef_quad_q) * 64'(temp_delta) * 64'(temp_delta)) >>> QUAD_SHIFT;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_scale_q <= GAIN_RST;
    end else if (ce) begin
      if (config_q[CFG_TEMP_EXT]) begin
        if (host_wr && host_addr == ADDR_GAIN) gain_scale_q <= host_wdata;
      end else if (pass_done) begin
        gain_scale_q <= GAIN_RST + lin_term[31:0] + quad_term[31:0];
      end
    end
  end

  // Sag detectors per phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
      sag_q    <= '0;
    end else if (ce && sample_valid) begin
      for (int p = 0; p < 2; p++) begin
        if (mag(p == 0 ? volt_a : volt_b) < uv_level_q) begin
          if (cnt_q[p] != 8'hff) cnt_q[p] <= cnt_q[p] + 8'h01;
          if ({1'b0, cnt_q[p]} + 9'h001 >= {1'b0, config_q[CFG_CNT_HI:CFG_CNT_LO]}) begin
            sag_q[p] <= 1'b1;
          end
        end else begin
          cnt_q[p] <= '0;
          if (mag(p == 0 ? volt_a : volt_b) > uv_level_q) sag_q[p] <= 1'b0;
        end
      end
    end
  end

  // Fundamental square wave and PLL phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fund_q        <= 1'b0;
      pll_phase_b_q <= 1'b0;
    end else if (ce) begin
      pll_phase_b_q <= config_q[CFG_SEL_HI:CFG_SEL_LO] == 2'b01;
      if (sample_valid) begin
        fund_q <= pll_phase_b_q ? !volt_b[31] : !volt_a[31];
      end
    end
  end

  // Status snapshot at pass end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (ce && pass_done) begin
      status_q           <= '0;
      status_q[ST_FUND]  <= fund_q;
      status_q[ST_SAG_B] <= sag_q[1];
      status_q[ST_SAG_A] <= sag_q[0];
    end
  end

  // Sag interrupt to the auxiliary pin
  assign sag_irq = (config_q[CFG_MASK_A] || config_q[CFG_MASK_B])
                   && (!config_q[CFG_MASK_A] || sag_q[0])
                   && (!config_q[CFG_MASK_B] || sag_q[1]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_pulse_pin_q <= 1'b0;
    end else if (ce) begin
      aux_pulse_pin_q <= config_q[CFG_SAG_INT] && sag_irq;
    end
  end

  // Shunt gain on current channels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_a_out_q <= '0;
      chan_b_out_q <= '0;
    end else if (ce) begin
      chan_a_out_q <= config_q[CFG_SHUNT_A] ? chan_a_in <<< SHUNT_SHIFT : chan_a_in;
      chan_b_out_q <= config_q[CFG_SHUNT_B] ? chan_b_in <<< SHUNT_SHIFT : chan_b_in;
    end
  end

  // Pulse generator source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_real_q     <= '0;
      pulse_reactive_q <= '0;
      pulse_two_q      <= '0;
      pulse_three_q    <= '0;
      pulse_gain_q     <= '0;
    end else if (ce) begin
      pulse_gain_q <= config_q[1:0];
      if (config_q[CFG_PSRC]) begin
        pulse_real_q     <= rate_q[0];
        pulse_reactive_q <= rate_q[1];
        pulse_two_q      <= rate_q[2];
        pulse_three_q    <= rate_q[3];
      end else begin
        pulse_two_q   <= '0;
        pulse_three_q <= '0;
        if (meter_equation == EQU_TWO_EL) begin
          pulse_real_q     <= elem0_real_energy + elem1_real_energy;
          pulse_reactive_q <= elem0_reactive_energy + elem1_reactive_energy;
        end else begin
          pulse_real_q <= (elem1_current_square > elem0_current_square)
                          ? elem1_real_energy : elem0_real_energy;
          pulse_reactive_q <= elem0_reactive_energy;
        end
      end
    end
  end

  // Read path, two cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rd_q      <= '0;
      sel_mem_q     <= 1'b0;
      rd_pend_q     <= 1'b0;
      host_rdata_q  <= '0;
      host_rvalid_q <= 1'b0;
    end else if (ce) begin
      rd_pend_q     <= host_rd;
      sel_mem_q     <= !mapped;
      host_rvalid_q <= rd_pend_q;
      unique case (host_addr)
        ADDR_CONFIG:    reg_rd_q <= config_q;
        ADDR_UV_LEVEL:  reg_rd_q <= uv_level_q;
        ADDR_GAIN:      reg_rd_q <= gain_scale_q;
        ADDR_RATE_REAL: reg_rd_q <= rate_q[0];
        ADDR_RATE_REAC: reg_rd_q <= rate_q[1];
        ADDR_RATE_TWO:  reg_rd_q <= rate_q[2];
        ADDR_RATE_THR:  reg_rd_q <= rate_q[3];
        ADDR_COEF_LIN:  reg_rd_q <= coef_lin_q;
        ADDR_COEF_QUAD: reg_rd_q <= coef_quad_q;
        ADDR_STATUS:    reg_rd_q <= status_q;
        default:        reg_rd_q <= '0;
      endcase
      if (rd_pend_q) host_rdata_q <= sel_mem_q ? mem_rdata : reg_rd_q;
    end
  end

  status_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_q[31:29] == 3'h0 && status_q[27] == 1'b0 && status_q[24:0] == 25'h0)
    else $error("status unused bits nonzero");
  status_snap_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pass_done |=> status_q[ST_SAG_A] == $past(sag_q[0])
                        && status_q[ST_SAG_B] == $past(sag_q[1]))
    else $error("status not refreshed at pass end");
  sag_a_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && sample_valid && mag(volt_a) < uv_level_q
    && {1'b0, cnt_q[0]} + 9'h001 >= {1'b0, config_q[15:8]} |=> sag_q[0])
    else $error("phase A sag flag not set");
  sag_b_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && sample_valid && mag(volt_b) > uv_level_q |=> !sag_q[1] && cnt_q[1] == 8'h00)
    else $error("phase B sag flag not cleared");
  aux_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> aux_pulse_pin_q == ($past(config_q[17]) && $past(sag_irq)))
    else $error("aux pin wrong");
  sag_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    config_q[19] && config_q[18] && !(sag_q[0] && sag_q[1]) |-> !sag_irq)
    else $error("sag interrupt without all phases");
  shunt_gain_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && config_q[2] |=> chan_a_out_q == ($past(chan_a_in) <<< 3))
    else $error("shunt gain missing");
  pulse_source_host_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && config_q[5] |=> pulse_real_q == $past(rate_q[0]))
    else $error("host pulse rate not used");
  eq_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !config_q[5] && meter_equation == 3'h2
    |=> pulse_reactive_q == $past(elem0_reactive_energy + elem1_reactive_energy))
    else $error("equation two sum wrong");
  eq_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !config_q[5] && meter_equation == 3'h0
    && elem1_current_square > elem0_current_square
    |=> pulse_real_q == $past(elem1_real_energy))
    else $error("larger element not chosen");
  gain_host_a: assert property (@(posedge clk) disable iff (!rst_n)
    config_q[16] && !(host_wr && host_addr == 8'h40) |=> $stable(gain_scale_q))
    else $error("engine touched host-owned gain");
endmodule

// file: sim/cesc_host.sv
`timescale 1ns/1ns
module cesc_host (
  // Clock
  input  wire logic        clk,
  // Word port into engine data RAM
  output logic             host_wr,
  output logic             host_rd,
  output logic [7:0]       host_addr,
  output logic [31:0]      host_wdata,
  input  wire logic [31:0] host_rdata_q,
  input  wire logic        host_rvalid_q
);
  initial begin
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_addr  = 8'h00;
    host_wdata = 32'h0;
  end

  // One word write; also how rate words are supplied
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask

  // One word read, bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d  = 32'h0;
    @(posedge clk);
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(posedge clk);
      #1;
      if (host_rvalid_q === 1'b1) begin
        ok = 1'b1;
        d  = host_rdata_q;
      end
    end
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  import cesc_pkg::*;
  logic               clk, rst_n, ce, pass_done, sample_valid, host_wr, host_rd, host_rvalid_q;
  logic               pll_phase_b_q, aux_pulse_pin_q;
  logic [7:0]         host_addr;
  logic [2:0]         meter_equation;
  logic [1:0]         pulse_gain_q;
  logic [31:0]        host_wdata, host_rdata_q, elem0_current_square, elem1_current_square;
  logic [31:0]        pulse_real_q, pulse_reactive_q, pulse_two_q, pulse_three_q, gain_scale_q;
  logic signed [31:0] volt_a, volt_b, temp_delta, chan_a_in, chan_b_in, chan_a_out_q, chan_b_out_q;
  logic signed [31:0] elem0_real_energy, elem1_real_energy;
  logic signed [31:0] elem0_reactive_energy, elem1_reactive_energy;
  logic signed [31:0] lo, hi;
  logic [31:0]        cfg, r0, r1, r2, r3;
  int                 err_count, compares, seed;

  cesc_top cesc_top_i (.clk, .rst_n, .ce, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata_q, .host_rvalid_q, .pass_done, .sample_valid, .volt_a, .volt_b, .temp_delta,
    .chan_a_in, .chan_b_in, .chan_a_out_q, .chan_b_out_q, .meter_equation, .elem0_real_energy,
    .elem1_real_energy, .elem0_reactive_energy, .elem1_reactive_energy, .elem0_current_square,
    .elem1_current_square, .pulse_real_q, .pulse_reactive_q, .pulse_two_q, .pulse_three_q,
    .pulse_gain_q, .pll_phase_b_q, .aux_pulse_pin_q, .gain_scale_q);
  cesc_host cesc_host_i (.clk, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata_q,
    .host_rvalid_q);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bit          ok;
    cesc_host_i.rd(a, d, ok);
    if (!ok) begin
      err_count++;
      conclude();
    end
    else chk(d, e);
  endtask

  task automatic smp(input logic signed [31:0] va, input logic signed [31:0] vb);
    @(posedge clk);
    volt_a       <= va;
    volt_b       <= vb;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask

  task automatic pass();
    @(posedge clk);
    pass_done <= 1'b1;
    @(posedge clk);
    pass_done <= 1'b0;
  endtask

  // Expected status word
  function automatic logic [31:0] st(input int b, input int a, input int f);
    return {3'h0, f[0], 1'b0, b[0], a[0], 25'h0};
  endfunction

  initial begin
    {rst_n, pass_done, sample_valid} = 3'h0;
    ce = 1'b1;
    meter_equation = 3'h0;
    {volt_a, volt_b, temp_delta, chan_a_in, chan_b_in} = '0;
    {elem0_real_energy, elem1_real_energy, elem0_reactive_energy, elem1_reactive_energy} = '0;
    {elem0_current_square, elem1_current_square} = '0;
    {err_count, compares} = 0;
    seed = 26065;
    lo = 32'sh100;
    hi = 32'sh0006_c279;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(ADDR_CONFIG, 32'h0000_5020);
    rdchk(8'h24, 32'h0006_c278);
    chk(gain_scale_q, 32'h0000_4000);
    cesc_host_i.wr(ADDR_CONFIG, 32'hfff0_0030);
    rdchk(ADDR_CONFIG, 32'h0000_0020);
    cesc_host_i.wr(ADDR_STATUS, 32'hffff_ffff);
    rdchk(ADDR_STATUS, 32'h0);
    // Sag detection, count of three, both masks, pin enabled
    cesc_host_i.wr(ADDR_CONFIG, 32'h000e_0320);
    smp(hi, hi);
    smp(lo, hi);
    smp(lo, hi);
    smp(32'sh0006_c278, hi);
    smp(lo, hi);
    smp(lo, hi);
    pass();
    rdchk(ADDR_STATUS, st(0, 0, 1));
    smp(-lo, hi);
    pass();
    rdchk(ADDR_STATUS, st(0, 1, 0));
    chk(32'(aux_pulse_pin_q), 32'h0);
    repeat (3) smp(-lo, lo);
    repeat (3) @(posedge clk);
    chk(32'(aux_pulse_pin_q), 32'h1);
    pass();
    rdchk(ADDR_STATUS, st(1, 1, 0));
    cesc_host_i.wr(ADDR_CONFIG, 32'h000c_0320);
    repeat (3) @(posedge clk);
    chk(32'(aux_pulse_pin_q), 32'h0);
    smp(hi, lo);
    rdchk(ADDR_STATUS, st(1, 1, 0));
    pass();
    rdchk(ADDR_STATUS, st(1, 0, 1));
    // Phase select for the fundamental bit
    cesc_host_i.wr(ADDR_CONFIG, 32'h0000_0360);
    smp(-lo, lo);
    pass();
    rdchk(ADDR_STATUS, st(1, 0, 1));
    chk(32'(pll_phase_b_q), 32'h1);
    cesc_host_i.wr(ADDR_CONFIG, 32'h0000_0320);
    smp(-lo, lo);
    pass();
    rdchk(ADDR_STATUS, st(1, 0, 0));
    chk(32'(pll_phase_b_q), 32'h0);
    // Clock enable low: sample and pass end both ignored
    @(posedge clk);
    ce <= 1'b0;
    smp(hi, hi);
    pass();
    @(posedge clk);
    ce <= 1'b1;
    rdchk(ADDR_STATUS, st(1, 0, 0));
    // Host rate words
    r0 = $random(seed);
    r1 = $random(seed);
    r2 = $random(seed);
    r3 = $random(seed);
    cesc_host_i.wr(ADDR_RATE_REAL, r0);
    cesc_host_i.wr(ADDR_RATE_REAC, r1);
    cesc_host_i.wr(ADDR_RATE_TWO, r2);
    cesc_host_i.wr(ADDR_RATE_THR, r3);
    // Shunt gain and pulse sources, random
    for (int i = 0; i < 12; i++) begin
      cfg = 32'h0001_0300 | ($random(seed) & 32'h0000_002d);
      cesc_host_i.wr(ADDR_CONFIG, cfg);
      @(posedge clk);
      chan_a_in <= $random(seed);
      chan_b_in <= $random(seed);
      meter_equation <= i[0] ? EQU_TWO_EL : EQU_ONE_EL;
      elem0_real_energy <= $random(seed);
      elem1_real_energy <= $random(seed);
      elem0_reactive_energy <= $random(seed);
      elem1_reactive_energy <= $random(seed);
      elem0_current_square <= (i < 2) ? 32'h10 : $random(seed);
      elem1_current_square <= (i < 2) ? 32'h10 : $random(seed);
      repeat (3) @(posedge clk);
      #1;
      chk(chan_a_out_q, cfg[CFG_SHUNT_A] ? chan_a_in * 8 : chan_a_in);
      chk(chan_b_out_q, cfg[CFG_SHUNT_B] ? chan_b_in * 8 : chan_b_in);
      chk(pulse_two_q, cfg[CFG_PSRC] ? r2 : 32'h0);
      chk(pulse_three_q, cfg[CFG_PSRC] ? r3 : 32'h0);
      chk(32'(pulse_gain_q), 32'(cfg[1:0]));
      if (cfg[CFG_PSRC]) begin
        chk(pulse_real_q, r0);
        chk(pulse_reactive_q, r1);
      end
      else if (i[0]) begin
        chk(pulse_real_q, elem0_real_energy + elem1_real_energy);
        chk(pulse_reactive_q, elem0_reactive_energy + elem1_reactive_energy);
      end
      else begin
        chk(pulse_real_q, (elem1_current_square > elem0_current_square) ?
          elem1_real_energy : elem0_real_energy);
        chk(pulse_reactive_q, elem0_reactive_energy);
      end
    end
    // Gain scale ownership
    r0 = $random(seed);
    cesc_host_i.wr(ADDR_GAIN, r0);
    repeat (2) @(posedge clk);
    chk(gain_scale_q, r0);
    cesc_host_i.wr(ADDR_CONFIG, 32'h0000_5020);
    cesc_host_i.wr(ADDR_GAIN, 32'h0000_1234);
    temp_delta <= $random(seed);
    pass();
    repeat (2) @(posedge clk);
    chk(gain_scale_q, 32'h0000_4000);
    conclude();
  end
endmodule
